/* pkg/ser_regs.svh */
// constants of the status and event reporting block
// How it works
// RULE1: event bits latch, later condition changes ignored
// RULE2: query or clear-status clears event register
// RULE3: reset command and device clear keep events
// RULE4: event query returns binary weighted decimal sum
// RULE5: summary bit ORs enabled event bits
// RULE6: enable registers read/write, clear-status keeps them
// RULE7: status bit 4 set while output queue holds
// RULE8: status summary bits follow sources, never latched
// RULE9: status bits 0-3 and 7 read zero
// RULE10: status bit 5 flags enabled standard events
// RULE11: status bit 6 shows service request exists
// RULE12: status query returns byte, changes nothing
// RULE13: clear-status clears events and discards output queue
// RULE14: service mask 8 bits, bit 6 forced zero
// RULE15: only mask weights 16 and 32 matter
// RULE16: event register cleared by read, clear, power-on
// RULE17: bit 0 set when pending operations finish
// RULE18: bit 1 never set; bit 2 query error
// RULE19: bit 3 set on device function failure
// RULE20: bit 4 range error; bit 5 command error
// RULE21: bit 6 local control; bit 7 power cycled
// RULE22: event mask 8 bits gates bits into summary
// RULE23: request service when status AND mask nonzero
`ifndef SER_REGS_SVH
`define SER_REGS_SVH

// reset values
`define SER_SRE_RESET 8'h00
`define SER_ESE_RESET 8'h00
`define SER_ESR_RESET 8'h80

// status byte field positions
`define SER_STB_MAV 4
`define SER_STB_ESB 5
`define SER_STB_MSS 6
`define SER_SRE_WMASK 8'hbf

// standard event field positions
`define SER_ESR_OPC 0
`define SER_ESR_RQC 1
`define SER_ESR_QYE 2
`define SER_ESR_DDE 3
`define SER_ESR_EXE 4
`define SER_ESR_CME 5
`define SER_ESR_URQ 6
`define SER_ESR_PON 7

// output queue geometry and characters
`define SER_Q_DEPTH 5'h10
`define SER_Q_AW 4
`define SER_ASCII_0 8'h30
`define SER_ASCII_LF 8'h0a

`endif

/* pkg/ser_pkg.sv */
// types of the status and event reporting block
package ser_pkg;

    // commands handed over by the command parser
    typedef enum logic [3:0] {
        SER_CMD_NOP   = 4'h0,
        SER_CMD_CLS   = 4'h1,
        SER_CMD_ESE_W = 4'h2,
        SER_CMD_ESE_Q = 4'h3,
        SER_CMD_ESR_Q = 4'h4,
        SER_CMD_SRE_W = 4'h5,
        SER_CMD_SRE_Q = 4'h6,
        SER_CMD_STB_Q = 4'h7,
        SER_CMD_OPC   = 4'h8,
        SER_CMD_RST   = 4'h9
    } ser_cmd_t;

    // answer formatter states, one-hot
    typedef enum logic [1:0] {
        SER_ST_IDLE = 2'b01,
        SER_ST_EMIT = 2'b10
    } ser_state_t;

endpackage : ser_pkg

/* pkg/ser_mem_if.sv */
// interface between the queue control and its character memory
interface ser_mem_if;
    logic wr_en;          // write one character
    logic [3:0] wr_addr;  // write slot
    logic [7:0] wr_data;  // character written
    logic rd_en;          // read one character
    logic [3:0] rd_addr;  // read slot
    logic [7:0] rd_data;  // registered read data

    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface : ser_mem_if

/* verilog/ser_mem.sv */
// character memory of the response output queue
module ser_mem
    import ser_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    ser_mem_if.mem port
);
    `include "ser_regs.svh"

    logic [7:0] store [0:15]; // queue slots, no reset needed
    logic [7:0] rd_data_q;    // read data register
    logic [7:0] rd_data_d;

    // read port: new data only on a read request
    always_comb begin
        rd_data_d = port.rd_en ? store[port.rd_addr] : rd_data_q;
    end

    // slots hold data only, so they stay out of the reset
    always_ff @(posedge clock) begin
        if (port.wr_en) begin
            store[port.wr_addr] <= port.wr_data;
        end
    end

    // registered read data
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign port.rd_data = rd_data_q;
endmodule : ser_mem

/* verilog/ser_evt.sv */
// latching standard event register
module ser_evt
    import ser_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] set,
    input wire logic clr,
    output logic [7:0] flags
);
    `include "ser_regs.svh"

    logic [7:0] flags_q; // latched events
    logic [7:0] flags_d;

    // a set arriving with the clear survives it
    always_comb begin
        flags_d = (clr ? 8'h00 : flags_q) | set; // RULE1
    end

    // power-on leaves only the power bit standing
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= `SER_ESR_RESET; // RULE16 RULE21
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;
endmodule : ser_evt

/* verilog/ser_top.sv */
// status byte, standard event and service request logic
module ser_top
    import ser_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    input wire logic ops_busy,
    input wire logic err_device,
    input wire logic err_exec,
    input wire logic err_command,
    input wire logic local_key,
    input wire logic dev_clr,
    input wire logic rd_req,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic mav,
    output logic [7:0] status_byte,
    output logic srq
);
    `include "ser_regs.svh"

    // ------------------------------------------------------------
    // decimal formatting of a byte: length and up to four characters
    // ------------------------------------------------------------
    function automatic logic [34:0] fmt_dec(input logic [7:0] v);
        logic [7:0] h;
        logic [7:0] t;
        logic [7:0] o;
        h = v / 8'd100;
        t = (v / 8'd10) % 8'd10;
        o = v % 8'd10;
        // leading zeros are dropped, a line feed ends the answer
        if (h != 8'h00) begin
            fmt_dec = {3'd4, h + `SER_ASCII_0, t + `SER_ASCII_0, o + `SER_ASCII_0, `SER_ASCII_LF};
        end else if (t != 8'h00) begin
            fmt_dec = {3'd3, t + `SER_ASCII_0, o + `SER_ASCII_0, `SER_ASCII_LF, 8'h00};
        end else begin
            fmt_dec = {3'd2, o + `SER_ASCII_0, `SER_ASCII_LF, 16'h0000};
        end
    endfunction : fmt_dec

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    // local control pin synchroniser
    logic [2:0] sy_q;       // three stage chain, [0] is first
    logic [2:0] sy_d;
    logic key_lvl_q;        // filtered pin level
    logic key_lvl_d;
    logic key_evt;          // filtered rising edge

    // programmed masks and operation complete arming
    logic [7:0] sre_q;      // service request mask
    logic [7:0] sre_d;
    logic [7:0] ese_q;      // standard event mask
    logic [7:0] ese_d;
    logic opc_arm_q;        // waiting for operations to finish
    logic opc_arm_d;
    logic opc_done;         // operations finished while armed

    // answer formatter
    ser_state_t st_q;
    ser_state_t st_d;
    logic [31:0] chars_q;   // characters still to push, msb first
    logic [31:0] chars_d;
    logic [2:0] nchar_q;    // characters still to push
    logic [2:0] nchar_d;
    logic cmd_ready_q;
    logic cmd_ready_d;

    // output queue pointers
    logic [3:0] wp_q;
    logic [3:0] wp_d;
    logic [3:0] rp_q;
    logic [3:0] rp_d;
    logic [4:0] cnt_q;      // characters held
    logic [4:0] cnt_d;
    logic push;             // formatter writes a character
    logic pop;              // reader takes a character
    logic flush;            // discard all unread characters
    logic q_full;
    logic qry_err;          // read with nothing present or pending
    logic pop_q;            // read data arrives one cycle later
    logic pop_d;
    logic rsp_valid_q;
    logic rsp_valid_d;
    logic [7:0] rsp_data_q;
    logic [7:0] rsp_data_d;

    // event register and status byte
    logic [7:0] esr_set;
    logic esr_clr;
    logic [7:0] esr_flags;
    logic [7:0] stb_now;    // live status byte with master summary
    logic mss;
    logic mav_q;
    logic mav_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic srq_q;
    logic srq_d;
    logic take;             // command accepted this cycle
    ser_cmd_t cmd;
    logic [34:0] fmt;       // formatted answer of a query
    logic [7:0] qval;       // value a query reports

    ser_mem_if mif ();

    // ------------------------------------------------------------
    // local control pin: three flops, a change counts once the
    // second and third agree, so a glitch shorter than a cycle is lost
    // ------------------------------------------------------------
    always_comb begin
        sy_d = {sy_q[1:0], local_key};
        key_lvl_d = (sy_q[1] == sy_q[2]) ? sy_q[2] : key_lvl_q;
        key_evt = (sy_q[1] == sy_q[2]) && sy_q[2] && !key_lvl_q; // RULE21
    end

    // synchroniser registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sy_q <= 3'h0;
            key_lvl_q <= 1'b0;
        end else begin
            sy_q <= sy_d;
            key_lvl_q <= key_lvl_d;
        end
    end

    // ------------------------------------------------------------
    // status byte: rebuilt from its sources every cycle, never held
    // ------------------------------------------------------------
    always_comb begin
        stb_now = 8'h00; // RULE9
        stb_now[`SER_STB_MAV] = (cnt_q != 5'h00); // RULE7
        stb_now[`SER_STB_ESB] = |(esr_flags & ese_q); // RULE5 RULE10 RULE22
        // mask bit 6 is held zero, so the master bit cannot feed itself
        mss = |(stb_now & sre_q & `SER_SRE_WMASK); // RULE15 RULE23
        stb_now[`SER_STB_MSS] = mss; // RULE11
    end

    // ------------------------------------------------------------
    // commands, masks and answer formatter
    // ------------------------------------------------------------
    always_comb begin
        take = cmd_valid && cmd_ready_q;
        cmd = ser_cmd_t'(cmd_code);
        sre_d = sre_q;
        ese_d = ese_q;
        st_d = st_q;
        chars_d = chars_q;
        nchar_d = nchar_q;
        esr_clr = 1'b0;
        flush = 1'b0;
        qval = 8'h00;
        fmt = fmt_dec(qval);
        push = (st_q == SER_ST_EMIT) && !q_full && !dev_clr;
        // an armed completion fires once nothing is busy
        opc_done = opc_arm_q && !ops_busy; // RULE17
        opc_arm_d = opc_arm_q && !opc_done;
        if (dev_clr) begin
            // device clear drops answers but keeps every event bit
            flush = 1'b1; // RULE3
            st_d = SER_ST_IDLE;
            nchar_d = 3'd0;
        end else if (take) begin
            case (cmd)
                SER_CMD_CLS: begin
                    esr_clr = 1'b1; // RULE2 RULE16
                    flush = 1'b1; // RULE13
                    opc_arm_d = 1'b0;
                end
                SER_CMD_ESE_W: begin
                    ese_d = cmd_data; // RULE22
                end
                SER_CMD_SRE_W: begin
                    sre_d = cmd_data & `SER_SRE_WMASK; // RULE14
                end
                SER_CMD_OPC: begin
                    opc_arm_d = 1'b1;
                end
                SER_CMD_RST: begin
                    // settings reset cancels the wait, events stay
                    opc_arm_d = 1'b0; // RULE3
                end
                SER_CMD_ESE_Q: begin
                    qval = ese_q; // RULE6
                    st_d = SER_ST_EMIT;
                end
                SER_CMD_SRE_Q: begin
                    qval = sre_q; // RULE6
                    st_d = SER_ST_EMIT;
                end
                SER_CMD_ESR_Q: begin
                    qval = esr_flags; // RULE4
                    esr_clr = 1'b1; // RULE2 RULE16
                    st_d = SER_ST_EMIT;
                end
                SER_CMD_STB_Q: begin
                    // reading the status byte changes nothing
                    qval = stb_now; // RULE12
                    st_d = SER_ST_EMIT;
                end
                default: begin
                    st_d = st_q;
                end
            endcase
            if (st_d == SER_ST_EMIT) begin
                fmt = fmt_dec(qval); // RULE4
                nchar_d = fmt[34:32];
                chars_d = fmt[31:0];
            end
        end else if (push) begin
            // one character per cycle, stalled while the queue is full
            chars_d = {chars_q[23:0], 8'h00};
            nchar_d = nchar_q - 3'd1;
            if (nchar_q == 3'd1) begin
                st_d = SER_ST_IDLE;
            end
        end
        cmd_ready_d = (st_d == SER_ST_IDLE);
    end

    // formatter and mask registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sre_q <= `SER_SRE_RESET;
            ese_q <= `SER_ESE_RESET;
            opc_arm_q <= 1'b0;
            st_q <= SER_ST_IDLE;
            chars_q <= 32'h0000_0000;
            nchar_q <= 3'd0;
            cmd_ready_q <= 1'b0;
        end else begin
            sre_q <= sre_d;
            ese_q <= ese_d;
            opc_arm_q <= opc_arm_d;
            st_q <= st_d;
            chars_q <= chars_d;
            nchar_q <= nchar_d;
            cmd_ready_q <= cmd_ready_d;
        end
    end

    // ------------------------------------------------------------
    // output queue control
    // ------------------------------------------------------------
    always_comb begin
        q_full = (cnt_q == `SER_Q_DEPTH);
        pop = rd_req && (cnt_q != 5'h00) && !flush;
        // an answer still being formatted counts as pending
        qry_err = rd_req && (cnt_q == 5'h00) && (st_q == SER_ST_IDLE); // RULE18
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (flush) begin
            wp_d = 4'h0;
            rp_d = 4'h0;
            cnt_d = 5'h00; // RULE13
        end else begin
            if (push) begin
                wp_d = wp_q + 4'h1;
            end
            if (pop) begin
                rp_d = rp_q + 4'h1;
            end
            case ({push, pop})
                2'b10: cnt_d = cnt_q + 5'h01;
                2'b01: cnt_d = cnt_q - 5'h01;
                default: cnt_d = cnt_q;
            endcase
        end
        pop_d = pop;
        rsp_valid_d = pop_q;
        rsp_data_d = pop_q ? mif.rd_data : rsp_data_q;
        mav_d = (cnt_d != 5'h00); // RULE7 RULE8
    end

    // queue pointers and answer registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= 4'h0;
            rp_q <= 4'h0;
            cnt_q <= 5'h00;
            pop_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 8'h00;
            mav_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            pop_q <= pop_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            mav_q <= mav_d;
        end
    end

    // memory ports
    assign mif.wr_en = push;
    assign mif.wr_addr = wp_q;
    assign mif.wr_data = chars_q[31:24];
    assign mif.rd_en = pop;
    assign mif.rd_addr = rp_q;

    ser_mem u_mem (
        .clock(clock),
        .rst_n(rst_n),
        .port(mif.mem)
    );

    // ------------------------------------------------------------
    // standard event sources; request control is never raised
    // ------------------------------------------------------------
    always_comb begin
        esr_set = 8'h00;
        esr_set[`SER_ESR_OPC] = opc_done; // RULE17
        esr_set[`SER_ESR_RQC] = 1'b0; // RULE18
        esr_set[`SER_ESR_QYE] = qry_err; // RULE18
        esr_set[`SER_ESR_DDE] = err_device; // RULE19
        esr_set[`SER_ESR_EXE] = err_exec; // RULE20
        esr_set[`SER_ESR_CME] = err_command; // RULE20
        esr_set[`SER_ESR_URQ] = key_evt; // RULE21
        esr_set[`SER_ESR_PON] = 1'b0;
    end

    ser_evt u_evt (
        .clock(clock),
        .rst_n(rst_n),
        .set(esr_set),
        .clr(esr_clr),
        .flags(esr_flags)
    );

    // ------------------------------------------------------------
    // registered status outputs, one cycle behind their sources
    // ------------------------------------------------------------
    always_comb begin
        status_d = stb_now; // RULE8
        srq_d = mss; // RULE23
    end

    // status output registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 8'h00;
            srq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            srq_q <= srq_d;
        end
    end

    assign cmd_ready = cmd_ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign mav = mav_q;
    assign status_byte = status_q;
    assign srq = srq_q;
endmodule : ser_top

/* test/ser_top_properties.sv */
// checker of the status byte, event and answer ports
module ser_top_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic cmd_ready,
    input wire logic dev_clr,
    input wire logic rd_req,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic mav,
    input wire logic [7:0] status_byte,
    input wire logic srq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic take; // a command accepted at this edge
    assign take = cmd_valid && cmd_ready && !dev_clr;
    property p_unused;
        status_byte[3:0] == 4'h0 && !status_byte[7];
    endproperty
    a_unused: assert property (p_unused) else $error("unused status bit set");
    // allow the one-cycle lag of the status register
    property p_mav_up;
        $rose(mav) |-> ##[0:2] status_byte[4];
    endproperty
    a_mav_up: assert property (p_mav_up) else $error("output bit late");
    property p_mav_low;
        !mav [*3] |-> !status_byte[4];
    endproperty
    a_mav_low: assert property (p_mav_low) else $error("output bit latched");
    property p_mss;
        status_byte[6] |-> (status_byte[5] || status_byte[4]);
    endproperty
    a_mss: assert property (p_mss) else $error("summary without cause");
    property p_srq;
        $rose(srq) |-> ##[0:2] status_byte[6];
    endproperty
    a_srq: assert property (p_srq) else $error("request without summary");
    // a clear-status taken with the read discards the character instead
    property p_rsp;
        rd_req && mav && !dev_clr && !(take && cmd_code == 4'h1) |-> ##2 rsp_valid;
    endproperty
    a_rsp: assert property (p_rsp) else $error("read not answered");
    property p_ascii;
        rsp_valid |-> (rsp_data == 8'h0a || (rsp_data >= 8'h30 && rsp_data <= 8'h39));
    endproperty
    a_ascii: assert property (p_ascii) else $error("answer not decimal");
    property p_cls;
        take && cmd_code == 4'h1 |-> ##[1:3] (!mav && !status_byte[5]);
    endproperty
    a_cls: assert property (p_cls) else $error("clear left state");
    property p_stb;
        take && cmd_code == 4'h7 |=> $stable(status_byte[5]);
    endproperty
    a_stb: assert property (p_stb) else $error("status query changed byte");
    c_srq: cover property ($rose(srq));
    c_lf: cover property (rsp_valid && rsp_data == 8'h0a);
    c_esb: cover property ($fell(status_byte[5]));
endmodule : ser_top_properties

bind ser_top ser_top_properties u_ser_top_properties (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .dev_clr(dev_clr), .rd_req(rd_req), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .mav(mav), .status_byte(status_byte), .srq(srq));

/* test/ser_host.sv */
// remote controller model: sends commands and reads answers
module ser_host (
    input wire logic clock,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic mav,
    output logic cmd_valid,
    output logic [3:0] cmd_code,
    output logic [7:0] cmd_data,
    output logic rd_req
);
    timeunit 1ns;
    timeprecision 100ps;
    int stalls = 0; // bounded waits that ran out
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 4'h0;
        cmd_data = 8'h00;
        rd_req = 1'b0;
    end
    // hold the command until an edge sees cmd_ready high
    task automatic send(input logic [3:0] code, input logic [7:0] data);
        int n;
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_data = data;
        for (n = 0; n < 40 && cmd_ready !== 1'b1; n++) @(negedge clock);
        if (n == 40) stalls++;
        @(negedge clock);
        cmd_valid = 1'b0;
    endtask : send
    // read request on its own, used to read an empty queue
    task automatic poke;
        @(negedge clock);
        rd_req = 1'b1;
        @(negedge clock);
        rd_req = 1'b0;
    endtask : poke
    // wait for data first, so a read never lands on an empty queue
    task automatic pull(output logic [7:0] ch);
        int n;
        for (n = 0; n < 40 && mav !== 1'b1; n++) @(negedge clock);
        if (n == 40) stalls++;
        poke();
        for (n = 0; n < 8 && rsp_valid !== 1'b1; n++) @(negedge clock);
        if (n == 8) stalls++;
        ch = rsp_data;
    endtask : pull
    // decimal digits up to the line feed
    task automatic query(input logic [3:0] code, output logic [7:0] v);
        logic [7:0] ch;
        logic [9:0] acc;
        int k;
        acc = 10'h000;
        send(code, 8'h00);
        for (k = 0; k < 5; k++) begin
            pull(ch);
            if (ch === 8'h0a) break;
            acc = 10'(acc * 10 + (ch - 8'h30));
        end
        if (k == 5) stalls++;
        v = acc[7:0];
    endtask : query
endmodule : ser_host

/* test/ser_tb.sv */
// self-checking bench of the status and event block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ser_pkg::*;
    logic clock = 1'b0;
    logic rst_n, ops_busy, local_key, dev_clr, rd_req, cmd_valid, cmd_ready, rsp_valid, mav, srq;
    logic [2:0] errs; // device, execution, command faults
    logic [3:0] cmd_code;
    logic [7:0] cmd_data, rsp_data, status_byte, v;
    int errors = 0;
    int comparisons = 0;
    always #4 clock = ~clock;
    ser_top u_ser_top (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .ops_busy(ops_busy), .err_device(errs[0]),
        .err_exec(errs[1]), .err_command(errs[2]), .local_key(local_key), .dev_clr(dev_clr),
        .rd_req(rd_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mav(mav),
        .status_byte(status_byte), .srq(srq));
    ser_host u_ser_host (.clock(clock), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .mav(mav), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data), .rd_req(rd_req));
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8
    task automatic conclude;
        errors += u_ser_host.stalls;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    // power bit after reset, then gone after one read
    task automatic t_power;
        check8(status_byte, 8'h00);
        u_ser_host.query(SER_CMD_ESR_Q, v);
        check8(v, 8'h80);
        u_ser_host.query(SER_CMD_ESR_Q, v);
        check8(v, 8'h00);
        $display("power test done");
    endtask : t_power
    // every weight of both masks, bit 6 of the service mask dropped
    task automatic t_masks;
        for (int i = 0; i < 8; i++) begin
            u_ser_host.send(SER_CMD_ESE_W, 8'h01 << i);
            u_ser_host.send(SER_CMD_SRE_W, 8'h01 << i);
            u_ser_host.query(SER_CMD_ESE_Q, v);
            check8(v, 8'h01 << i);
            u_ser_host.query(SER_CMD_ESE_Q, v);
            check8(v, 8'h01 << i);
            u_ser_host.query(SER_CMD_SRE_Q, v);
            check8(v, (8'h01 << i) & 8'hbf);
        end
        u_ser_host.send(SER_CMD_ESE_W, 8'h00);
        u_ser_host.send(SER_CMD_SRE_W, 8'h00);
        u_ser_host.query(SER_CMD_SRE_Q, v);
        check8(v, 8'h00);
        $display("mask test done");
    endtask : t_masks
    // causes dropped again at once must stay recorded
    task automatic t_events;
        errs = 3'b111;
        tick(1);
        errs = 3'b000;
        local_key = 1'b1;
        tick(6);
        local_key = 1'b0;
        u_ser_host.poke();
        tick(3);
        u_ser_host.query(SER_CMD_ESR_Q, v);
        check8(v, 8'h7c);
        u_ser_host.query(SER_CMD_ESR_Q, v);
        check8(v, 8'h00);
        $display("event test done");
    endtask : t_events
    // summary through both masks, then reset command and device clear
    task automatic t_summary;
        u_ser_host.send(SER_CMD_ESE_W, 8'h10);
        u_ser_host.send(SER_CMD_SRE_W, 8'h20);
        errs = 3'b010;
        tick(1);
        errs = 3'b000;
        tick(3);
        check8(status_byte, 8'h60);
        check8({7'h00, srq}, 8'h01);
        u_ser_host.query(SER_CMD_STB_Q, v);
        check8(v, 8'h60);
        dev_clr = 1'b1;
        tick(1);
        dev_clr = 1'b0;
        u_ser_host.send(SER_CMD_RST, 8'h00);
        tick(3);
        check8(status_byte, 8'h60);
        u_ser_host.send(SER_CMD_CLS, 8'h00);
        tick(3);
        check8(status_byte, 8'h00);
        check8({7'h00, srq}, 8'h00);
        u_ser_host.query(SER_CMD_ESE_Q, v);
        check8(v, 8'h10);
        $display("summary test done");
    endtask : t_summary
    // unread answer raises the output bit until clear-status drops it
    task automatic t_mav;
        u_ser_host.send(SER_CMD_SRE_W, 8'h10);
        u_ser_host.send(SER_CMD_ESE_Q, 8'h00);
        tick(8);
        check8(status_byte, 8'h50);
        check8({7'h00, srq}, 8'h01);
        u_ser_host.send(SER_CMD_SRE_W, 8'h8f);
        tick(3);
        check8(status_byte, 8'h10);
        check8({7'h00, srq}, 8'h00);
        u_ser_host.send(SER_CMD_CLS, 8'h00);
        tick(3);
        check8({7'h00, mav}, 8'h00);
        $display("output test done");
    endtask : t_mav
    // completion flag waits for pending operations
    task automatic t_opc;
        u_ser_host.send(SER_CMD_ESE_W, 8'h01);
        ops_busy = 1'b1;
        u_ser_host.send(SER_CMD_OPC, 8'h00);
        tick(6);
        check8(status_byte, 8'h00);
        ops_busy = 1'b0;
        tick(4);
        check8(status_byte, 8'h20);
        u_ser_host.query(SER_CMD_ESR_Q, v);
        check8(v, 8'h01);
        $display("completion test done");
    endtask : t_opc
    initial begin
        rst_n = 1'b0;
        errs = 3'b000;
        ops_busy = 1'b0;
        local_key = 1'b0;
        dev_clr = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        tick(2);
        t_power();
        t_masks();
        t_events();
        t_summary();
        t_mav();
        t_opc();
        conclude();
    end
    // hang guard
    initial begin
        repeat (30000) @(posedge clock);
        errors++;
        conclude();
    end
endmodule : tb
